// ===== design/pbr_parity_reporter.sv
// How it works
// R1 - Sec master parity bit needs master, response
// R2 - Sec master bit only downstream, secondary bus
// R3 - Primary PERR only as write target/read initiator
// R4 - Primary PERR needs primary parity response
// R5 - Primary PERR: up read, down writes
// R6 - Sec PERR on down delayed completion forwards
// R7 - Secondary PERR needs role and sec response
// R8 - Secondary PERR: down read, up writes
// R9 - Pri PERR on up delayed completion forwards
// R10 - SERR on target-bus PERR in posted write
// R11 - No SERR when bridge itself was target
// R12 - SERR needs both response bits, posted only
// R13 - SERR never without system-error enable
// R14 - SERR also sets signaled system error bit
// R15 - Status bits sticky, write one clears
`timescale 1ns/1ps
`default_nettype none

module pbr_parity_reporter
	import pbr_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Register port
	input wire logic [PBR_ADDR_W-1:0] reg_addr,
	input wire logic [PBR_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [PBR_DATA_W-1:0] reg_rdata,
	// Parity-error event from the data path
	input wire pbr_event_t err_event,
	// Primary parity-error pin
	input wire logic pri_parity_err_n_in,
	output logic pri_parity_err_n_out,
	output logic pri_parity_err_n_oe,
	// Secondary parity-error pin
	input wire logic sec_parity_err_n_in,
	output logic sec_parity_err_n_out,
	output logic sec_parity_err_n_oe,
	// Primary system-error pin, open drain
	output logic pri_system_err_n_out,
	output logic pri_system_err_n_oe,
	// Interrupt
	output logic irq
);

	// Pin synchronisers, first and second stage
	logic pri_perr_meta_n;
	logic pri_perr_sync_n;
	logic sec_perr_meta_n;
	logic sec_perr_sync_n;

	// Software registers
	logic [PBR_CTRL_W-1:0] ctrl;
	logic [PBR_ST_W-1:0] status;
	logic [PBR_ST_W-1:0] mask;

	// Decoded control bits
	logic pri_resp;
	logic sec_resp;
	logic serr_en;

	// Per-event decisions
	logic set_sec_mdp;
	logic fire_pri_perr;
	logic fire_sec_perr;
	logic fire_serr;
	logic [PBR_ST_W-1:0] status_set;

	// Bus strobes decoded
	logic wr_status;
	logic [PBR_ST_W-1:0] status_clr;

	// Pin drive state
	logic [1:0] perr_fire;
	pbr_pin_t perr_pin [2];
	logic [1:0] serr_cnt;

	// Control fields
	assign pri_resp = ctrl[PBR_CTRL_PRI_RESP];
	assign sec_resp = ctrl[PBR_CTRL_SEC_RESP];
	assign serr_en = ctrl[PBR_CTRL_SERR_EN];

	// Primary pin synchroniser
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pri_perr_meta_n <= 1'b1;
			pri_perr_sync_n <= 1'b1;
		end else if (clk_en) begin
			pri_perr_meta_n <= pri_parity_err_n_in;
			pri_perr_sync_n <= pri_perr_meta_n;
		end
	end

	// Secondary pin synchroniser
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sec_perr_meta_n <= 1'b1;
			sec_perr_sync_n <= 1'b1;
		end else if (clk_en) begin
			sec_perr_meta_n <= sec_parity_err_n_in;
			sec_perr_sync_n <= sec_perr_meta_n;
		end
	end

	// Secondary master data parity decision
	always_comb begin
		set_sec_mdp = 1'b0;
		// R2 downstream secondary only
		if (err_event.valid && err_event.dir == PBR_DIR_DOWN &&
			err_event.bus == PBR_BUS_SEC) begin
			// R1 master, response, error seen
			set_sec_mdp = sec_resp && (err_event.self_det || !sec_perr_sync_n);
		end
	end

	// Primary parity-error pin decision
	always_comb begin
		fire_pri_perr = 1'b0;
		if (err_event.valid) begin
			case (err_event.kind)
				PBR_KIND_READ: begin
					// R5 upstream read on primary
					fire_pri_perr = err_event.dir == PBR_DIR_UP &&
						err_event.bus == PBR_BUS_PRI && err_event.self_det;
				end
				PBR_KIND_POSTED: begin
					// R3 bridge is write target
					fire_pri_perr = err_event.dir == PBR_DIR_DOWN &&
						err_event.bus == PBR_BUS_PRI && err_event.self_det;
				end
				PBR_KIND_DELAYED: begin
					if (err_event.dir == PBR_DIR_DOWN) begin
						if (err_event.bus == PBR_BUS_PRI) begin
							// R5 downstream delayed write
							fire_pri_perr = err_event.self_det;
						end else begin
							// R6 forwarded from secondary pin
							fire_pri_perr = err_event.completion && !sec_perr_sync_n &&
								sec_resp;
						end
					end
				end
				default: begin
					fire_pri_perr = 1'b0;
				end
			endcase
		end
		// R4 primary parity response gate
		fire_pri_perr = fire_pri_perr && pri_resp;
	end

	// Secondary parity-error pin decision
	always_comb begin
		fire_sec_perr = 1'b0;
		if (err_event.valid) begin
			case (err_event.kind)
				PBR_KIND_READ: begin
					// R8 downstream read on secondary
					fire_sec_perr = err_event.dir == PBR_DIR_DOWN &&
						err_event.bus == PBR_BUS_SEC && err_event.self_det;
				end
				PBR_KIND_POSTED: begin
					// R8 upstream posted write target
					fire_sec_perr = err_event.dir == PBR_DIR_UP &&
						err_event.bus == PBR_BUS_SEC && err_event.self_det;
				end
				PBR_KIND_DELAYED: begin
					if (err_event.dir == PBR_DIR_UP) begin
						if (err_event.bus == PBR_BUS_SEC) begin
							// R8 upstream delayed write
							fire_sec_perr = err_event.self_det;
						end else begin
							// R9 forwarded from primary pin
							fire_sec_perr = err_event.completion && !pri_perr_sync_n &&
								pri_resp;
						end
					end
				end
				default: begin
					fire_sec_perr = 1'b0;
				end
			endcase
		end
		// R7 secondary response gate
		fire_sec_perr = fire_sec_perr && sec_resp;
	end

	// System-error decision for posted writes
	always_comb begin
		fire_serr = 1'b0;
		// R12 posted writes only
		if (err_event.valid && err_event.kind == PBR_KIND_POSTED) begin
			// R10 target-bus pin seen asserted
			if (err_event.dir == PBR_DIR_UP && err_event.bus == PBR_BUS_PRI) begin
				fire_serr = !pri_perr_sync_n;
			end else if (err_event.dir == PBR_DIR_DOWN && err_event.bus == PBR_BUS_SEC) begin
				fire_serr = !sec_perr_sync_n;
			end
			// R11 not when bridge was target
			if (err_event.self_det) begin
				fire_serr = 1'b0;
			end
		end
		// R12 both responses; R13 enable
		fire_serr = fire_serr && pri_resp && sec_resp && serr_en;
	end

	// Status set vector
	always_comb begin
		status_set = '0;
		status_set[PBR_ST_SEC_MDP] = set_sec_mdp;
		// R14 signaled system error
		status_set[PBR_ST_SIG_SERR] = fire_serr;
		status_set[PBR_ST_PRI_PERR] = fire_pri_perr;
		status_set[PBR_ST_SEC_PERR] = fire_sec_perr;
	end

	// Write-one-to-clear decode
	assign wr_status = reg_wr && reg_addr == PBR_OFF_STATUS;
	assign status_clr = wr_status ? reg_wdata[PBR_ST_W-1:0] : '0;

	// Control register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= PBR_CTRL_RESET;
		end else if (clk_en && reg_wr && reg_addr == PBR_OFF_CTRL) begin
			ctrl <= reg_wdata[PBR_CTRL_W-1:0];
		end
	end

	// Mask register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mask <= PBR_MASK_RESET;
		end else if (clk_en && reg_wr && reg_addr == PBR_OFF_MASK) begin
			mask <= reg_wdata[PBR_ST_W-1:0];
		end
	end

	// Sticky status, set beats clear
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			// R15 cleared by reset
			status <= PBR_STATUS_RESET;
		end else if (clk_en) begin
			// R15 write one clears
			status <= (status & ~status_clr) | status_set;
		end
	end

	// Read data, valid only the cycle after the strobe
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= '0;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					PBR_OFF_CTRL: begin
						reg_rdata <= {{(PBR_DATA_W-PBR_CTRL_W){1'b0}}, ctrl};
					end
					PBR_OFF_STATUS: begin
						reg_rdata <= {{(PBR_DATA_W-PBR_ST_W){1'b0}}, status};
					end
					PBR_OFF_MASK: begin
						reg_rdata <= {{(PBR_DATA_W-PBR_ST_W){1'b0}}, mask};
					end
					PBR_OFF_LIVE: begin
						// Synchronised pin levels
						reg_rdata <= {{(PBR_DATA_W-2){1'b0}}, sec_perr_sync_n, pri_perr_sync_n};
					end
					default: begin
						// Unmapped reads as zero
						reg_rdata <= '0;
					end
				endcase
			end else begin
				reg_rdata <= '0;
			end
		end
	end

	// Interrupt level
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(((status & ~status_clr) | status_set) & mask);
		end
	end

	// Triggers for the two parity-error pins
	assign perr_fire = {fire_sec_perr, fire_pri_perr};

	// Parity-error pin drivers: low, then high, then released
	for (genvar i = 0; i < 2; i++) begin : g_perr
		logic [1:0] phase_cnt;
		logic driving_low;

		// Sequence counter and pin drive
		always_ff @(posedge ref_clk or negedge reset_n) begin
			if (!reset_n) begin
				phase_cnt <= 2'h0;
				driving_low <= 1'b0;
				perr_pin[i] <= '{out: 1'b1, oe: 1'b0};
			end else if (clk_en) begin
				if (perr_fire[i]) begin
					// New error restarts the assert phase
					phase_cnt <= PBR_PERR_ASSERT_CYC - 2'h1;
					driving_low <= 1'b1;
					perr_pin[i] <= '{out: 1'b0, oe: 1'b1};
				end else if (phase_cnt != 2'h0) begin
					phase_cnt <= phase_cnt - 2'h1;
				end else if (driving_low) begin
					// Drive high before release
					driving_low <= 1'b0;
					phase_cnt <= PBR_PERR_RELEASE_CYC - 2'h1;
					perr_pin[i] <= '{out: 1'b1, oe: 1'b1};
				end else begin
					perr_pin[i] <= '{out: 1'b1, oe: 1'b0};
				end
			end
		end
	end

	// Pin outputs straight from the driver flops
	assign pri_parity_err_n_out = perr_pin[0].out;
	assign pri_parity_err_n_oe = perr_pin[0].oe;
	assign sec_parity_err_n_out = perr_pin[1].out;
	assign sec_parity_err_n_oe = perr_pin[1].oe;

	// System-error pin, open drain, pulled low for a fixed time
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			serr_cnt <= 2'h0;
			pri_system_err_n_oe <= 1'b0;
		end else if (clk_en) begin
			if (fire_serr) begin
				// R10 assert system error
				serr_cnt <= PBR_SERR_ASSERT_CYC - 2'h1;
				pri_system_err_n_oe <= 1'b1;
			end else if (serr_cnt != 2'h0) begin
				serr_cnt <= serr_cnt - 2'h1;
			end else begin
				pri_system_err_n_oe <= 1'b0;
			end
		end
	end

	// Open drain only ever pulls low
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pri_system_err_n_out <= 1'b0;
		end else begin
			pri_system_err_n_out <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ===== design/pbr_pkg.sv
// Shared constants and types for the bridge parity-error reporter
package pbr_pkg;

	// Register bus widths
	localparam int PBR_ADDR_W = 8;
	localparam int PBR_DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] PBR_OFF_CTRL = 8'h00;
	localparam logic [7:0] PBR_OFF_STATUS = 8'h04;
	localparam logic [7:0] PBR_OFF_MASK = 8'h08;
	localparam logic [7:0] PBR_OFF_LIVE = 8'h0c;

	// Control register field positions
	localparam int PBR_CTRL_PRI_RESP = 0;
	localparam int PBR_CTRL_SERR_EN = 1;
	localparam int PBR_CTRL_SEC_RESP = 2;
	localparam int PBR_CTRL_W = 3;

	// Status and mask field positions
	localparam int PBR_ST_SEC_MDP = 0;
	localparam int PBR_ST_SIG_SERR = 1;
	localparam int PBR_ST_PRI_PERR = 2;
	localparam int PBR_ST_SEC_PERR = 3;
	localparam int PBR_ST_W = 4;

	// Values after reset
	localparam logic [2:0] PBR_CTRL_RESET = 3'h0;
	localparam logic [3:0] PBR_STATUS_RESET = 4'h0;
	localparam logic [3:0] PBR_MASK_RESET = 4'h0;

	// Parity-error pin drive: cycles asserted, then cycles driven high
	localparam logic [1:0] PBR_PERR_ASSERT_CYC = 2'h1;
	localparam logic [1:0] PBR_PERR_RELEASE_CYC = 2'h1;
	// Cycles the system-error pin is pulled low
	localparam logic [1:0] PBR_SERR_ASSERT_CYC = 2'h1;

	// Transaction kinds
	typedef enum logic [1:0] {
		PBR_KIND_READ = 2'h0,
		PBR_KIND_POSTED = 2'h1,
		PBR_KIND_DELAYED = 2'h2
	} pbr_kind_t;

	// Transfer direction
	typedef enum logic {
		PBR_DIR_DOWN = 1'b0,
		PBR_DIR_UP = 1'b1
	} pbr_dir_t;

	// Bus on which the error was seen
	typedef enum logic {
		PBR_BUS_PRI = 1'b0,
		PBR_BUS_SEC = 1'b1
	} pbr_bus_t;

	// One parity-error event from the bridge data path
	typedef struct packed {
		logic valid;
		pbr_kind_t kind;
		pbr_dir_t dir;
		pbr_bus_t bus;
		logic self_det;
		logic completion;
	} pbr_event_t;

	// Open-drain or tristate pin drive
	typedef struct packed {
		logic out;
		logic oe;
	} pbr_pin_t;

endpackage

// ===== dv/pbr_chk.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the reporter
module pbr_chk
	import pbr_pkg::*;
(
	// Clock and register port
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [PBR_ADDR_W-1:0] reg_addr,
	input wire logic [PBR_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [PBR_DATA_W-1:0] reg_rdata,
	// Event and pins
	input wire pbr_event_t err_event,
	input wire logic pri_parity_err_n_in,
	input wire logic pri_parity_err_n_out,
	input wire logic pri_parity_err_n_oe,
	input wire logic sec_parity_err_n_in,
	input wire logic sec_parity_err_n_out,
	input wire logic sec_parity_err_n_oe,
	input wire logic pri_system_err_n_out,
	input wire logic pri_system_err_n_oe,
	input wire logic irq
);
	logic [2:0] ctrl; // Mirror of control bits
	logic ev; // Event taken
	logic pri_low; // Primary line pulled
	logic sec_low; // Secondary line pulled
	logic pri_cause; // Event under primary response
	logic sec_cause; // Event under secondary response
	logic serr_cause; // Posted error not self-detected, both responses

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	assign ev = clk_en && err_event.valid;
	assign pri_low = pri_parity_err_n_oe && !pri_parity_err_n_out;
	assign sec_low = sec_parity_err_n_oe && !sec_parity_err_n_out;
	assign pri_cause = ev && ctrl[PBR_CTRL_PRI_RESP];
	assign sec_cause = ev && ctrl[PBR_CTRL_SEC_RESP];
	assign serr_cause = ev && err_event.kind == PBR_KIND_POSTED && !err_event.self_det
		&& ctrl[PBR_CTRL_PRI_RESP] && ctrl[PBR_CTRL_SEC_RESP];

	// Follows control writes
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= PBR_CTRL_RESET;
		end else if (clk_en && reg_wr && reg_addr == PBR_OFF_CTRL) begin
			ctrl <= reg_wdata[2:0];
		end
	end

	// Upstream read error seen on primary
	sequence s_pri_fire;
		ev && err_event.self_det && err_event.bus == PBR_BUS_PRI && ctrl[PBR_CTRL_PRI_RESP]
			&& err_event.kind == PBR_KIND_READ && err_event.dir == PBR_DIR_UP;
	endsequence
	// Downstream read error seen on secondary
	sequence s_sec_fire;
		ev && err_event.self_det && err_event.bus == PBR_BUS_SEC && ctrl[PBR_CTRL_SEC_RESP]
			&& err_event.kind == PBR_KIND_READ && err_event.dir == PBR_DIR_DOWN;
	endsequence

	a_pri_perr_fire: assert property (s_pri_fire |=> pri_low)
		else $error("primary parity line not pulled");
	a_pri_perr_gate: assert property (pri_low |-> $past(pri_cause))
		else $error("primary parity line pulled without cause");
	a_pri_perr_hold: assert property (pri_low |=> pri_parity_err_n_oe)
		else $error("primary parity line released early");
	a_sec_perr_fire: assert property (s_sec_fire |=> sec_low)
		else $error("secondary parity line not pulled");
	a_sec_perr_gate: assert property (sec_low |-> $past(sec_cause))
		else $error("secondary parity line pulled without cause");
	a_serr_enable: assert property (pri_system_err_n_oe |-> $past(ctrl[PBR_CTRL_SERR_EN]))
		else $error("system error without enable");
	a_serr_posted_only: assert property (pri_system_err_n_oe |-> $past(serr_cause))
		else $error("system error from wrong event");
	a_serr_drive_low: assert property (pri_system_err_n_oe |-> !pri_system_err_n_out)
		else $error("system error line not low");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
endmodule

bind pbr_parity_reporter pbr_chk pbr_chk_inst (
	.ref_clk(ref_clk),
	.reset_n(reset_n),
	.clk_en(clk_en),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.err_event(err_event),
	.pri_parity_err_n_in(pri_parity_err_n_in),
	.pri_parity_err_n_out(pri_parity_err_n_out),
	.pri_parity_err_n_oe(pri_parity_err_n_oe),
	.sec_parity_err_n_in(sec_parity_err_n_in),
	.sec_parity_err_n_out(sec_parity_err_n_out),
	.sec_parity_err_n_oe(sec_parity_err_n_oe),
	.pri_system_err_n_out(pri_system_err_n_out),
	.pri_system_err_n_oe(pri_system_err_n_oe),
	.irq(irq)
);

`default_nettype wire

// ===== dv/pbr_peer_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side agents sharing the two parity lines
module pbr_peer_model (
	// Pull requests from the bench
	input wire logic pri_pull,
	input wire logic sec_pull,
	// Bridge drive of the lines
	input wire logic pri_out,
	input wire logic pri_oe,
	input wire logic sec_out,
	input wire logic sec_oe,
	// Resolved line levels
	output logic pri_wire,
	output logic sec_wire
);
	// Pulled up; low if any party drives low
	assign pri_wire = !(pri_pull || (pri_oe && !pri_out));
	assign sec_wire = !(sec_pull || (sec_oe && !sec_out));
endmodule

`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

// Register-level regression of the reporter
module tb
	import pbr_pkg::*;
;
	logic ref_clk = 1'b0; // Bench clock
	logic reset_n = 1'b0; // Reset, low at start
	logic clk_en = 1'b1; // Advance enable
	logic [7:0] addr = 8'h00; // Register address
	logic [31:0] wdata = 32'h0; // Write data
	logic wr = 1'b0; // Write strobe
	logic rd = 1'b0; // Read strobe
	logic [31:0] rdata; // Read data
	pbr_event_t ev = 7'h00; // Error event
	logic pri_pull = 1'b0; // Peer pulls primary line
	logic sec_pull = 1'b0; // Peer pulls secondary line
	logic pri_wire, sec_wire, pri_out, pri_oe, sec_out, sec_oe, serr_out, serr_oe, irq;
	logic [2:0] ctl_set [4] = '{3'h7, 3'h1, 3'h4, 3'h0}; // Response settings
	// Kind, dir, bus, ctrl, expected status
	logic [10:0] cases [9] = '{11'h4f5, 11'h490, 11'h578, 11'h540, 11'h372,
		11'h2f3, 11'h2d1, 11'h330, 11'h170};
	logic [10:0] cs; // Current case
	logic p, s, m; // Expected pulls and master bit
	int bad_count = 0;
	int tests_run = 0;

	pbr_parity_reporter pbr_parity_reporter_inst (.ref_clk(ref_clk), .reset_n(reset_n),
		.clk_en(clk_en), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .err_event(ev), .pri_parity_err_n_in(pri_wire),
		.pri_parity_err_n_out(pri_out), .pri_parity_err_n_oe(pri_oe),
		.sec_parity_err_n_in(sec_wire), .sec_parity_err_n_out(sec_out),
		.sec_parity_err_n_oe(sec_oe), .pri_system_err_n_out(serr_out),
		.pri_system_err_n_oe(serr_oe), .irq(irq));

	pbr_peer_model pbr_peer_model_inst (.pri_pull(pri_pull), .sec_pull(sec_pull),
		.pri_out(pri_out), .pri_oe(pri_oe), .sec_out(sec_out), .sec_oe(sec_oe),
		.pri_wire(pri_wire), .sec_wire(sec_wire));

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle register write
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	// One-cycle read, data in next cycle
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask

	// One-cycle event, outputs settled after
	task automatic fire(input pbr_kind_t k, input pbr_dir_t d, input pbr_bus_t b,
		input logic sd);
		@(posedge ref_clk);
		ev <= {1'b1, k, d, b, sd, k == PBR_KIND_DELAYED};
		@(posedge ref_clk);
		ev <= 7'h00;
		#1;
	endtask

	// Verdict and end of run
	task automatic final_report;
		if (bad_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Clock
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Hang guard
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		final_report();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd_reg(PBR_OFF_CTRL, 32'h0);
		rd_reg(PBR_OFF_STATUS, 32'h0);
		rd_reg(PBR_OFF_MASK, 32'h0);
		rd_reg(PBR_OFF_LIVE, 32'h3);
		rd_reg(8'h10, 32'h0);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr_reg(PBR_OFF_MASK, 32'hf);
		clk_en <= 1'b1;
		rd_reg(PBR_OFF_MASK, 32'h0);
		wr_reg(PBR_OFF_MASK, 32'h2);
		// Self-detected errors, every combination
		for (int c = 0; c < 4; c++) begin
			wr_reg(PBR_OFF_CTRL, {29'h0, ctl_set[c]});
			for (int i = 0; i < 12; i++) begin
				fire(pbr_kind_t'(i / 4), pbr_dir_t'(i[1]), pbr_bus_t'(i[0]), 1'b1);
				p = ctl_set[c][0] && !i[0] && ((i / 4 == 0) == i[1]);
				s = ctl_set[c][2] && i[0] && ((i / 4 == 0) == !i[1]);
				m = ctl_set[c][2] && i[0] && !i[1];
				check({pri_oe & ~pri_out, sec_oe & ~sec_out, serr_oe}, {p, s, 1'b0});
				rd_reg(PBR_OFF_STATUS, {28'h0, s, p, 1'b0, m});
				wr_reg(PBR_OFF_STATUS, 32'hf);
				rd_reg(PBR_OFF_STATUS, 32'h0);
			end
		end
		// Errors signalled by peers on the lines
		for (int i = 0; i < 9; i++) begin
			cs = cases[i];
			wr_reg(PBR_OFF_CTRL, {29'h0, cs[6:4]});
			pri_pull <= !cs[7];
			sec_pull <= cs[7];
			repeat (3) @(posedge ref_clk);
			// Pulled line seen through the synchronisers
			rd_reg(PBR_OFF_LIVE, {30'h0, !cs[7], cs[7]});
			fire(pbr_kind_t'(cs[10:9]), pbr_dir_t'(cs[8]), pbr_bus_t'(cs[7]), 1'b0);
			check({pri_oe & ~pri_out, sec_oe & ~sec_out, serr_oe, irq}, {cs[2], cs[3], cs[1], cs[1]});
			pri_pull <= 1'b0;
			sec_pull <= 1'b0;
			rd_reg(PBR_OFF_STATUS, {28'h0, cs[3:0]});
			wr_reg(PBR_OFF_STATUS, 32'hf);
		end
		// Reset in mid-run clears status
		fire(PBR_KIND_READ, PBR_DIR_UP, PBR_BUS_PRI, 1'b1);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		@(posedge ref_clk);
		reset_n <= 1'b1;
		rd_reg(PBR_OFF_STATUS, 32'h0);
		rd_reg(PBR_OFF_CTRL, 32'h0);
		final_report();
	end
endmodule

`default_nettype wire
